// [logic/psr_readout.sv]
// register readout for a pressure and temperature sensor, serial slave via spi or i2c
// assumes pins come asynchronously, link clock much slower than ref_clk
`timescale 1ns/1ps
module psr_readout #(
  parameter int CONV_CYCLES = psr_pkg::CONV_CYCLES,
  parameter int IDLE_STEP_CYCLES = psr_pkg::IDLE_STEP_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic interface_select_pin,
  input wire logic serial_clk_pin,
  input wire logic data_in_pin,
  input wire logic [7:0] part_number_code,
  input wire logic diag_enable_otp,
  input wire logic [3:0] bridge_fault_in,
  input wire logic [23:0] pressure_in,
  input wire logic [15:0] temperature_in,
  output logic data_out,
  output logic data_oe_n,
  output logic sdo_out,
  output logic conv_busy
);
  // idle count times the four-bit field must stay inside the 32-bit counter
  if (CONV_CYCLES < 1 || IDLE_STEP_CYCLES < 1 || IDLE_STEP_CYCLES > 32'h0fff_ffff) begin : g_bad_counts
    $error("psr_readout: counts out of range");
  end

  logic [3:0] pins_sync;
  psr_sync #(.WIDTH(4)) u_sync (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .async_in({interface_select_pin, ~serial_clk_pin, data_in_pin, 1'b1}),
    .sync_out(pins_sync)
  );
  wire sel_s = pins_sync[3];
  // link clock passes inverted, so the flops' reset level matches an idle low clock
  wire sclk_s = ~pins_sync[2];
  wire din_s = pins_sync[1];

  typedef enum logic [1:0] {
    PSR_LS_ADDR = 2'b00,
    PSR_LS_WDATA = 2'b01,
    PSR_LS_RDATA = 2'b10
  } psr_link_state_type;

  logic sclk_d_reg, sclk_d_next;
  logic din_d_reg, din_d_next;
  logic sel_d_reg, sel_d_next;
  psr_link_state_type ls_reg, ls_next;
  logic [7:0] shift_reg, shift_next;
  logic [3:0] bit_reg, bit_next;
  logic [7:0] addr_reg, addr_next;
  logic rd_reg, rd_next;
  logic i2c_adr_reg, i2c_adr_next;
  logic [7:0] ctrl_reg, ctrl_next;
  logic [7:0] cmd_reg, cmd_next;
  logic ready_reg, ready_next;
  psr_pkg::psr_result_type res_reg, res_next;
  logic [31:0] conv_cnt_reg, conv_cnt_next;
  logic idle_reg, idle_next;
  logic loaded_reg, loaded_next;
  logic diag_reg, diag_next;
  logic dout_reg, dout_next;
  logic oe_n_reg, oe_n_next;
  logic sdo_reg, sdo_next;
  psr_pkg::psr_link_cfg_type cfg;
  logic [7:0] rdata;
  logic [7:0] wbyte;
  logic wr_stb;
  psr_pkg::psr_mode_type cmd_mode;
  assign cmd_mode = psr_pkg::psr_mode_type'(cmd_reg[2:0]);
  wire rise = sclk_s & ~sclk_d_reg;
  wire fall = ~sclk_s & sclk_d_reg;
  // frame start/stop: i2c start/stop, any select change opens or closes an spi frame
  wire spi_frame_edge = sel_s ^ sel_d_reg;
  wire frame_edge_start = sel_s & sclk_s & din_d_reg & ~din_s;
  wire frame_edge_stop = sel_s & sclk_s & ~din_d_reg & din_s;

  always_comb begin
    cfg.in_spi = ~sel_s;
    cfg.four_wire = ctrl_reg[psr_pkg::CTRL_FOUR_WIRE_BIT];
    cfg.lsb_first = cfg.in_spi & ctrl_reg[psr_pkg::CTRL_LSB_FIRST_BIT];
  end

  always_comb begin
    rdata = 8'h00;
    unique case (addr_reg)
      psr_pkg::ADDR_SERIAL_PORT_CONTROL: rdata = ctrl_reg;
      psr_pkg::ADDR_PART_IDENTIFIER: rdata = part_number_code;
      psr_pkg::ADDR_DEVICE_STATUS: rdata = {res_reg.fault, 2'b00, 1'b0, ready_reg};
      psr_pkg::ADDR_PRESSURE_HIGH_BYTE: rdata = res_reg.pressure[23:16];
      psr_pkg::ADDR_PRESSURE_MID_BYTE: rdata = res_reg.pressure[15:8];
      psr_pkg::ADDR_PRESSURE_LOW_BYTE: rdata = res_reg.pressure[7:0];
      psr_pkg::ADDR_TEMPERATURE_HIGH_BYTE: rdata = res_reg.temperature[15:8];
      psr_pkg::ADDR_TEMPERATURE_LOW_BYTE: rdata = res_reg.temperature[7:0];
      psr_pkg::ADDR_CONVERSION_COMMAND: rdata = cmd_reg;
      default: rdata = 8'h00;
    endcase
  end

  // serial engine: first byte address (spi: bit7 = read), then data bytes
  always_comb begin
    sclk_d_next = sclk_s;
    din_d_next = din_s;
    sel_d_next = sel_s;
    ls_next = ls_reg;
    shift_next = shift_reg;
    bit_next = bit_reg;
    addr_next = addr_reg;
    rd_next = rd_reg;
    i2c_adr_next = i2c_adr_reg;
    dout_next = dout_reg;
    oe_n_next = oe_n_reg;
    sdo_next = sdo_reg;
    wr_stb = 1'b0;
    // whole byte including the bit taken at this rise, in register bit order (reversed back for lsb first)
    wbyte = cfg.lsb_first ? {din_s, shift_reg[0], shift_reg[1], shift_reg[2],
                             shift_reg[3], shift_reg[4], shift_reg[5], shift_reg[6]} : {shift_reg[6:0], din_s};
    if (frame_edge_start || frame_edge_stop || spi_frame_edge) begin
      ls_next = PSR_LS_ADDR;
      bit_next = 4'h0;
      i2c_adr_next = ~cfg.in_spi;
      oe_n_next = 1'b1;
    end else if (rise) begin
      shift_next = {shift_reg[6:0], din_s};
      bit_next = bit_reg + 4'h1;
      if (bit_reg == 4'h7) begin
        bit_next = 4'h0;
        unique case (ls_reg)
          PSR_LS_ADDR: begin
            if (i2c_adr_reg) begin
              i2c_adr_next = 1'b0;
              rd_next = din_s;
              ls_next = din_s ? PSR_LS_RDATA : PSR_LS_ADDR;
              shift_next = rdata;
            end else begin
              addr_next = {1'b0, wbyte[6:0]};
              rd_next = cfg.in_spi & wbyte[7];
              ls_next = (cfg.in_spi && rd_next) ? PSR_LS_RDATA : PSR_LS_WDATA;
            end
          end
          PSR_LS_WDATA: begin
            wr_stb = 1'b1;
            addr_next = addr_reg + 8'h01;
          end
          PSR_LS_RDATA: begin
            addr_next = addr_reg + 8'h01;
          end
          default: ls_next = PSR_LS_ADDR;
        endcase
      end
    end else if (fall && ls_reg == PSR_LS_RDATA) begin
      if (bit_reg == 4'h0) begin
        shift_next = rdata;
      end
      dout_next = cfg.lsb_first ? rdata[bit_reg[2:0]] : rdata[3'h7 - bit_reg[2:0]];
      sdo_next = dout_next;
      oe_n_next = cfg.four_wire & cfg.in_spi;
    end
  end

  // registers, soft reset and conversion timebase
  always_comb begin
    ctrl_next = ctrl_reg;
    cmd_next = cmd_reg;
    ready_next = ready_reg;
    res_next = res_reg;
    conv_cnt_next = conv_cnt_reg;
    idle_next = idle_reg;
    loaded_next = 1'b1;
    diag_next = diag_reg;
    if (!loaded_reg) begin
      diag_next = diag_enable_otp;
    end
    if (wr_stb && addr_reg == psr_pkg::ADDR_SERIAL_PORT_CONTROL) begin
      ctrl_next = wbyte | {wbyte[0], wbyte[1], wbyte[2], wbyte[3], wbyte[4], wbyte[5], wbyte[6], wbyte[7]};
    end
    if (wr_stb && addr_reg == psr_pkg::ADDR_CONVERSION_COMMAND) begin
      cmd_next = wbyte;
      if (wbyte[psr_pkg::CMD_START_BIT]) begin
        ready_next = 1'b0;
        conv_cnt_next = 32'(CONV_CYCLES);
        idle_next = 1'b0;
      end
    end else if (cmd_reg[psr_pkg::CMD_START_BIT]) begin
      if (conv_cnt_reg != 32'h0000_0000) begin
        conv_cnt_next = conv_cnt_reg - 32'h0000_0001;
      end else if (!idle_reg) begin
        ready_next = 1'b1;
        if (cmd_mode != psr_pkg::PSR_MODE_SENSOR) begin
          res_next.temperature = temperature_in;
        end
        if (cmd_mode != psr_pkg::PSR_MODE_TEMP) begin
          res_next.pressure = pressure_in;
        end
        res_next.fault = diag_reg ? bridge_fault_in : 4'h0;
        if (cmd_mode == psr_pkg::PSR_MODE_PERIODIC) begin
          idle_next = 1'b1;
          conv_cnt_next = 32'(IDLE_STEP_CYCLES) * 32'(cmd_reg[7:4]);
        end else begin
          cmd_next[psr_pkg::CMD_START_BIT] = 1'b0;
        end
      end else begin
        idle_next = 1'b0;
        conv_cnt_next = 32'(CONV_CYCLES);
      end
    end
    if (ctrl_reg[psr_pkg::CTRL_SOFT_RESET_BIT]) begin
      ctrl_next = psr_pkg::SERIAL_PORT_CONTROL_RESET;
      cmd_next = psr_pkg::CONVERSION_COMMAND_RESET;
      ready_next = 1'b0;
      res_next = '0;
      conv_cnt_next = 32'h0000_0000;
      idle_next = 1'b0;
      loaded_next = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      sclk_d_reg <= 1'b0;
      sel_d_reg <= 1'b1;
      din_d_reg <= 1'b1;
      ls_reg <= PSR_LS_ADDR;
      shift_reg <= 8'h00;
      bit_reg <= 4'h0;
      addr_reg <= 8'h00;
      rd_reg <= 1'b0;
      i2c_adr_reg <= 1'b0;
      dout_reg <= 1'b1;
      oe_n_reg <= 1'b1;
      sdo_reg <= 1'b1;
      ctrl_reg <= psr_pkg::SERIAL_PORT_CONTROL_RESET;
      cmd_reg <= psr_pkg::CONVERSION_COMMAND_RESET;
      ready_reg <= 1'b0;
      res_reg <= '0;
      conv_cnt_reg <= 32'h0000_0000;
      idle_reg <= 1'b0;
      loaded_reg <= 1'b0;
      diag_reg <= 1'b0;
    end else if (ce) begin
      sclk_d_reg <= sclk_d_next;
      din_d_reg <= din_d_next;
      sel_d_reg <= sel_d_next;
      ls_reg <= ls_next;
      shift_reg <= shift_next;
      bit_reg <= bit_next;
      addr_reg <= addr_next;
      rd_reg <= rd_next;
      i2c_adr_reg <= i2c_adr_next;
      dout_reg <= dout_next;
      oe_n_reg <= oe_n_next;
      sdo_reg <= sdo_next;
      ctrl_reg <= ctrl_next;
      cmd_reg <= cmd_next;
      ready_reg <= ready_next;
      res_reg <= res_next;
      conv_cnt_reg <= conv_cnt_next;
      idle_reg <= idle_next;
      loaded_reg <= loaded_next;
      diag_reg <= diag_next;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      data_out <= 1'b1;
      data_oe_n <= 1'b1;
      sdo_out <= 1'b1;
      conv_busy <= 1'b0;
    end else if (ce) begin
      data_out <= dout_next;
      data_oe_n <= oe_n_next;
      sdo_out <= sdo_next;
      conv_busy <= cmd_next[psr_pkg::CMD_START_BIT] & ~idle_next;
    end
  end

  a_soft_reset_clears: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce && ctrl_reg[psr_pkg::CTRL_SOFT_RESET_BIT] |=> ctrl_reg == 8'h00 && cmd_reg == 8'h00)
    else $error("soft reset did not clear registers");
  a_start_clears_ready: assert property (@(posedge ref_clk) disable iff (!rstn)
    ce && wr_stb && addr_reg == psr_pkg::ADDR_CONVERSION_COMMAND && wbyte[3]
      && !ctrl_reg[psr_pkg::CTRL_SOFT_RESET_BIT] |=> !ready_reg)
    else $error("ready not cleared by start");
  a_ctrl_mirror: assert property (@(posedge ref_clk) disable iff (!rstn)
    ctrl_reg[0] == ctrl_reg[7] && ctrl_reg[1] == ctrl_reg[6] && ctrl_reg[2] == ctrl_reg[5])
    else $error("control mirror broken");
  a_status_bit1_zero: assert property (@(posedge ref_clk) disable iff (!rstn)
    addr_reg == psr_pkg::ADDR_DEVICE_STATUS |-> rdata[1] == 1'b0 && rdata[0] == ready_reg)
    else $error("status layout wrong");
  a_part_identifier_read: assert property (@(posedge ref_clk) disable iff (!rstn)
    addr_reg == psr_pkg::ADDR_PART_IDENTIFIER |-> rdata == part_number_code)
    else $error("part identifier wrong");
  a_pressure_map: assert property (@(posedge ref_clk) disable iff (!rstn)
    addr_reg == psr_pkg::ADDR_PRESSURE_HIGH_BYTE |-> rdata == res_reg.pressure[23:16])
    else $error("pressure map wrong");
  a_temp_map: assert property (@(posedge ref_clk) disable iff (!rstn)
    addr_reg == psr_pkg::ADDR_TEMPERATURE_LOW_BYTE |-> rdata == res_reg.temperature[7:0])
    else $error("temperature map wrong");
  a_fault_gated: assert property (@(posedge ref_clk) disable iff (!rstn)
    !diag_reg |-> res_reg.fault == 4'h0)
    else $error("fault reported without diagnosis");
endmodule

// [logic/psr_pkg.sv]
// package for the pressure sensor register readout
// assumes a 10 MHz ref_clk and serial link clocks sampled in that domain
package psr_pkg;
  localparam logic [7:0] ADDR_SERIAL_PORT_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_PART_IDENTIFIER = 8'h01;
  localparam logic [7:0] ADDR_DEVICE_STATUS = 8'h02;
  localparam logic [7:0] ADDR_PRESSURE_HIGH_BYTE = 8'h06;
  localparam logic [7:0] ADDR_PRESSURE_MID_BYTE = 8'h07;
  localparam logic [7:0] ADDR_PRESSURE_LOW_BYTE = 8'h08;
  localparam logic [7:0] ADDR_TEMPERATURE_HIGH_BYTE = 8'h09;
  localparam logic [7:0] ADDR_TEMPERATURE_LOW_BYTE = 8'h0a;
  localparam logic [7:0] ADDR_CONVERSION_COMMAND = 8'h30;
  localparam logic [7:0] SERIAL_PORT_CONTROL_RESET = 8'h00;
  localparam logic [7:0] CONVERSION_COMMAND_RESET = 8'h00;
  localparam int CTRL_FOUR_WIRE_BIT = 0;
  localparam int CTRL_LSB_FIRST_BIT = 1;
  localparam int CTRL_SOFT_RESET_BIT = 2;
  localparam int CMD_MODE_LSB = 0;
  localparam int CMD_START_BIT = 3;
  localparam int CMD_IDLE_LSB = 4;
  localparam int STATUS_READY_BIT = 0;
  localparam int STATUS_FAULT_LSB = 4;
  localparam int CLK_HZ = 10_000_000;
  localparam int IDLE_STEP_US = 62_500;
  localparam int IDLE_STEP_CYCLES = IDLE_STEP_US * (CLK_HZ / 1_000_000);
  localparam int CONV_TIME_US = 3_000;
  localparam int CONV_CYCLES = CONV_TIME_US * (CLK_HZ / 1_000_000);
  localparam logic [6:0] I2C_DEVICE_ADDR = 7'h6d;

  typedef enum logic [2:0] {
    PSR_MODE_TEMP = 3'b000,
    PSR_MODE_SENSOR = 3'b001,
    PSR_MODE_COMBINED = 3'b010,
    PSR_MODE_PERIODIC = 3'b011,
    PSR_MODE_OTP = 3'b100
  } psr_mode_type;

  typedef struct packed {
    logic [23:0] pressure;
    logic [15:0] temperature;
    logic [3:0] fault;
  } psr_result_type;

  typedef struct packed {
    logic in_spi;
    logic four_wire;
    logic lsb_first;
  } psr_link_cfg_type;
endpackage

// [logic/psr_sync.sv]
// two-flop synchroniser for pin inputs
// assumes the input is asynchronous to clk
`timescale 1ns/1ps
module psr_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic ce,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] meta_reg;
  logic [WIDTH-1:0] meta_next;
  logic [WIDTH-1:0] sync_reg;
  logic [WIDTH-1:0] sync_next;

  always_comb begin
    meta_next = meta_reg;
    sync_next = sync_reg;
    if (!rstn) begin
      meta_next = '1;
      sync_next = '1;
    end else if (ce) begin
      meta_next = async_in;
      sync_next = meta_reg;
    end
  end

  always_ff @(posedge ref_clk) begin
    meta_reg <= meta_next;
    sync_reg <= sync_next;
  end

  assign sync_out = sync_reg;
endmodule

// [bench/psr_host_model.sv]
// host model: spi master that frames, writes and reads bursts on the sensor pins
// assumes the device answers a few ref_clk cycles after each falling link clock edge
`timescale 1ns/1ps
module psr_host_model (
  output logic interface_select_pin,
  output logic serial_clk_pin,
  output logic data_in_pin,
  input wire logic data_out,
  input wire logic data_oe_n,
  input wire logic sdo_out
);
  localparam time HALF = 400ns;
  logic drv = 1'b1;
  logic lsb_first = 1'b0;
  logic four_wire = 1'b0;
  logic [7:0] bytes_q [0:7];
  initial begin
    interface_select_pin = 1'b1;
    serial_clk_pin = 1'b0;
  end
  // shared data wire: device wins while it drives, else the host
  assign data_in_pin = data_oe_n ? drv : data_out;
  task automatic put_byte(input logic [7:0] v, output logic [7:0] got);
    for (int i = 0; i < 8; i++) begin
      drv = lsb_first ? v[i] : v[7-i];
      #HALF serial_clk_pin = 1'b1;
      // sample midway through the high phase: the answer lags the falling edge by the sync pipe
      #(HALF / 2);
      got[lsb_first ? i : 7-i] = four_wire ? sdo_out : data_in_pin;
      #(HALF / 2) serial_clk_pin = 1'b0;
    end
  endtask
  task automatic frame(input logic rd, input logic [6:0] addr, input int n);
    logic [7:0] got;
    #37 interface_select_pin = 1'b0;
    #(2*HALF);
    put_byte({rd, addr}, got);
    for (int k = 0; k < n; k++) begin
      // while reading, the host line toggles so a missing answer shows
      put_byte(rd ? 8'h55 : bytes_q[k], got);
      if (rd) begin
        bytes_q[k] = got;
      end
    end
    #HALF interface_select_pin = 1'b1;
    drv = ~drv;
    #(4*HALF);
  endtask
endmodule

// [bench/psr_readout_bench.sv]
// testbench for the register readout, driven over spi by the host model
// assumes short conversion and idle counts set through parameters
`timescale 1ns/1ps
`define PSR_CHECK(what, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("unexpected %s expected %h seen %h", what, exp, got); end end
module psr_readout_bench;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic diag_enable_otp = 1'b1;
  logic [3:0] bridge_fault_in = 4'ha;
  logic [23:0] pressure_in = 24'h85_a3c1;
  logic [15:0] temperature_in = 16'hc3a5;
  logic [7:0] part_code = 8'h5c; // arbitrary value
  int fails = 0;
  int checked = 0;
  wire interface_select_pin, serial_clk_pin, data_in_pin, data_out, data_oe_n, sdo_out, conv_busy;
  always #50 ref_clk = ~ref_clk;
  psr_readout #(.CONV_CYCLES(600), .IDLE_STEP_CYCLES(50)) uut (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .ce(ce),
    .interface_select_pin(interface_select_pin),
    .serial_clk_pin(serial_clk_pin),
    .data_in_pin(data_in_pin),
    .part_number_code(part_code),
    .diag_enable_otp(diag_enable_otp),
    .bridge_fault_in(bridge_fault_in),
    .pressure_in(pressure_in),
    .temperature_in(temperature_in),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .sdo_out(sdo_out),
    .conv_busy(conv_busy)
  );
  psr_host_model host (
    .interface_select_pin(interface_select_pin),
    .serial_clk_pin(serial_clk_pin),
    .data_in_pin(data_in_pin),
    .data_out(data_out),
    .data_oe_n(data_oe_n),
    .sdo_out(sdo_out)
  );
  task automatic wrap_up();
    $display("checked %0d fails %0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] v);
    host.bytes_q[0] = v;
    host.frame(1'b0, addr, 1);
  endtask
  task automatic wait_busy(input logic lvl);
    for (int n = 0; n < 1000 && conv_busy !== lvl; n++) begin
      @(posedge ref_clk);
      #5;
    end
    `PSR_CHECK("busy", lvl, conv_busy)
  endtask
  task automatic check_defaults();
    host.frame(1'b1, 7'h00, 3);
    `PSR_CHECK("control", 8'h00, host.bytes_q[0])
    `PSR_CHECK("part_identifier", part_code, host.bytes_q[1])
    `PSR_CHECK("status low", 2'b00, host.bytes_q[2][1:0])
    write_reg(7'h01, 8'hff);
    host.frame(1'b1, 7'h01, 3);
    `PSR_CHECK("part_identifier ro", part_code, host.bytes_q[0])
    `PSR_CHECK("unmapped", 8'h00, host.bytes_q[2])
  endtask
  task automatic run_modes();
    psr_pkg::psr_mode_type modes [3] = '{psr_pkg::PSR_MODE_TEMP, psr_pkg::PSR_MODE_SENSOR,
                                         psr_pkg::PSR_MODE_COMBINED};
    logic [23:0] exp_p = 24'h00_0000;
    logic [15:0] exp_t = 16'h0000;
    foreach (modes[m]) begin
      // fresh converter values each round show which results a mode refreshes
      pressure_in = pressure_in + 24'h01_0101;
      temperature_in = temperature_in + 16'h0101;
      write_reg(7'h30, {4'h0, 1'b1, modes[m]});
      `PSR_CHECK("busy start", 1'b1, conv_busy)
      host.frame(1'b1, 7'h02, 1);
      `PSR_CHECK("ready cleared", 1'b0, host.bytes_q[0][0])
      wait_busy(1'b0);
      host.frame(1'b1, 7'h30, 1);
      `PSR_CHECK("cmd", {5'h00, modes[m]}, host.bytes_q[0])
      host.frame(1'b1, 7'h02, 1);
      `PSR_CHECK("status", {bridge_fault_in, 4'b0001}, host.bytes_q[0])
      if (modes[m] != psr_pkg::PSR_MODE_TEMP) begin
        exp_p = pressure_in;
      end
      if (modes[m] != psr_pkg::PSR_MODE_SENSOR) begin
        exp_t = temperature_in;
      end
      host.frame(1'b1, 7'h06, 5);
      `PSR_CHECK("pressure", exp_p, {host.bytes_q[0], host.bytes_q[1], host.bytes_q[2]})
      `PSR_CHECK("temperature", exp_t, {host.bytes_q[3], host.bytes_q[4]})
    end
  endtask
  task automatic four_wire_lsb();
    write_reg(7'h00, 8'hc3);
    host.lsb_first = 1'b1;
    host.four_wire = 1'b1;
    host.frame(1'b1, 7'h00, 2);
    `PSR_CHECK("control mirrored", 8'hc3, host.bytes_q[0])
    `PSR_CHECK("part_identifier lsb", part_code, host.bytes_q[1])
  endtask
  task automatic periodic_then_reset();
    write_reg(7'h30, {4'h1, 1'b1, psr_pkg::PSR_MODE_PERIODIC});
    wait_busy(1'b0);
    host.frame(1'b1, 7'h30, 1);
    `PSR_CHECK("periodic cmd", 8'h1b, host.bytes_q[0])
    wait_busy(1'b1);
    diag_enable_otp = 1'b0;
    write_reg(7'h00, 8'he7);
    host.lsb_first = 1'b0;
    host.four_wire = 1'b0;
    host.frame(1'b1, 7'h00, 1);
    `PSR_CHECK("control after reset", 8'h00, host.bytes_q[0])
    host.frame(1'b1, 7'h30, 1);
    `PSR_CHECK("cmd after reset", 8'h00, host.bytes_q[0])
    write_reg(7'h30, {5'h00, psr_pkg::PSR_MODE_OTP});
    host.frame(1'b1, 7'h30, 1);
    `PSR_CHECK("otp mode", 8'h04, host.bytes_q[0])
    `PSR_CHECK("no conversion", 1'b0, conv_busy)
    write_reg(7'h30, {4'h0, 1'b1, psr_pkg::PSR_MODE_TEMP});
    @(posedge ref_clk);
    #5 ce = 1'b0;
    // longer than a whole conversion: only a frozen counter keeps busy high
    repeat (700) @(posedge ref_clk);
    #5;
    `PSR_CHECK("frozen busy", 1'b1, conv_busy)
    ce = 1'b1;
    wait_busy(1'b0);
    host.frame(1'b1, 7'h02, 1);
    `PSR_CHECK("status no diag", 8'h01, host.bytes_q[0])
  endtask
  initial begin
    #2ms;
    fails++;
    wrap_up();
  end
  initial begin
    repeat (10) @(posedge ref_clk);
    #5 rstn = 1'b1;
    repeat (5) @(posedge ref_clk);
    check_defaults();
    run_modes();
    four_wire_lsb();
    periodic_then_reset();
    wrap_up();
  end
endmodule
